// >>> hw/rtp_pkg.sv
// package: register map, field layout and timing constants for the timer pair
package rtp_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_GROUP_CTRL   = 8'h0E;
   localparam logic [7:0] IDX_T0_RELOAD_HI = 8'h10;
   localparam logic [7:0] IDX_T0_RELOAD_LO = 8'h11;
   localparam logic [7:0] IDX_T0_COUNT_HI  = 8'h12;
   localparam logic [7:0] IDX_T0_COUNT_LO  = 8'h13;
   localparam logic [7:0] IDX_T1_CONTROL   = 8'h14;
   localparam logic [7:0] IDX_T1_RELOAD_HI = 8'h15;
   localparam logic [7:0] IDX_T1_RELOAD_LO = 8'h16;
   localparam logic [7:0] IDX_T1_COUNT_HI  = 8'h17;
   localparam logic [7:0] IDX_T1_COUNT_LO  = 8'h18;
   localparam logic [7:0] IDX_IRQ_STATUS   = 8'h20;

   // second timer control field positions
   localparam int CTRL_STOP_RX_BIT = 7;
   localparam int CTRL_START_LSB   = 4;
   localparam int CTRL_AUTO_BIT    = 3;
   localparam int CTRL_CLK_LSB     = 0;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hBB;

   // group control: running bits above, modify mask below
   localparam int GRP_RUN_LSB  = 4;
   localparam int GRP_MASK_LSB = 0;

   // status register: underflow flag, write one to clear
   localparam int IRQ_FLAG_BIT = 0;

   // start modes
   localparam logic [1:0] START_NONE    = 2'h0;
   localparam logic [1:0] START_TX_END  = 2'h1;
   localparam logic [1:0] START_TRIM    = 2'h2;
   localparam logic [1:0] START_TRIM_UF = 2'h3;

   // clock sources
   localparam logic [1:0] CLK_BASE   = 2'h0;
   localparam logic [1:0] CLK_SLOW   = 2'h1;
   localparam logic [1:0] CLK_CASC_A = 2'h2;
   localparam logic [1:0] CLK_CASC_B = 2'h3;

   // reset values
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] RELOAD_RST = 16'h0000;

   // timing: base tick is 13.56 MHz from a fractional accumulator
   localparam int SYS_CLK_HZ   = 100_000_000;
   localparam int BASE_TICK_HZ = 13_560_000;
   localparam int ACC_SCALE    = 10_000;
   localparam logic [13:0] ACC_STEP = 14'(BASE_TICK_HZ / ACC_SCALE);
   localparam logic [13:0] ACC_MOD  = 14'(SYS_CLK_HZ / ACC_SCALE);
   localparam int SLOW_DIV = 64;
   localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);

   typedef enum logic {PH_IDLE, PH_WAIT} rtp_phase_t;

endpackage

// >>> hw/rtp_timer_regs.sv
// module: timer pair with register file on an AHB-Lite slave port
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module rtp_timer_regs #(
   parameter int ADDR_W = 10
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // front end events, same clock
   input  wire logic              tx_done,
   input  wire logic              rx_nibble_done,
   input  wire logic              third_underflow,
   // low frequency oscillator pin
   input  wire logic              low_freq_oscillator,
   // timer events
   output logic                   first_underflow,
   output logic                   second_underflow,
   output logic                   second_underflow_irq
);
   import rtp_pkg::*;

   rtp_phase_t  phase_reg, phase_next;
   logic [7:0]  idx_reg, idx_next;
   logic        wr_reg, wr_next;
   logic        rdy_reg, rdy_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [13:0] acc_reg, acc_next;
   logic        base_tick_reg, base_tick_next;
   logic [5:0]  slow_cnt_reg, slow_cnt_next;
   logic        slow_tick_reg, slow_tick_next;
   logic        osc_s1_reg, osc_s2_reg, osc_s3_reg;
   logic [15:0] t0_reload_reg, t0_reload_next;
   logic [15:0] t0_cnt_reg, t0_cnt_next;
   logic        t0_run_reg, t0_run_next;
   logic        t0_uf_reg, t0_uf_next;
   logic [7:0]  t1_ctrl_reg, t1_ctrl_next;
   logic [15:0] t1_reload_reg, t1_reload_next;
   logic [15:0] t1_cnt_reg, t1_cnt_next;
   logic        t1_run_reg, t1_run_next;
   logic        t1_uf_reg, t1_uf_next;
   logic        irq_reg, irq_next;

   logic        wr_en, rd_en, osc_rise, t1_tick, trim, trim_no_uf;
   logic        start0, stop0, start1, stop1, auto_start1;
   logic [1:0]  mode1, sel1;
   logic [7:0]  wdata;

   assign mode1      = t1_ctrl_reg[CTRL_START_LSB +: 2];
   assign sel1       = t1_ctrl_reg[CTRL_CLK_LSB +: 2];
   assign trim       = mode1[1];
   assign trim_no_uf = (mode1 == START_TRIM);
   assign wdata      = hwdata[7:0];
   assign wr_en      = (phase_reg == PH_WAIT) && wr_reg;
   assign rd_en      = (phase_reg == PH_WAIT) && !wr_reg;
   // only the second and third sync stages feed the edge detector
   assign osc_rise   = osc_s2_reg && !osc_s3_reg;

   always_comb begin
      unique case (sel1)
         CLK_BASE:   t1_tick = base_tick_reg;
         CLK_SLOW:   t1_tick = slow_tick_reg;
         CLK_CASC_A: t1_tick = t0_uf_reg;
         CLK_CASC_B: t1_tick = third_underflow;
      endcase
   end

   // group control: a running bit moves only under its mask bit
   always_comb begin
      logic grp_wr;
      grp_wr = wr_en && (idx_reg == IDX_GROUP_CTRL);
      start0 = grp_wr && wdata[GRP_MASK_LSB] && wdata[GRP_RUN_LSB];
      stop0  = grp_wr && wdata[GRP_MASK_LSB] && !wdata[GRP_RUN_LSB];
      start1 = grp_wr && wdata[GRP_MASK_LSB+1] && wdata[GRP_RUN_LSB+1];
      stop1  = grp_wr && wdata[GRP_MASK_LSB+1] && !wdata[GRP_RUN_LSB+1];
      auto_start1 = tx_done && (mode1 == START_TX_END);
   end

   // bus phase, register writes and read data
   always_comb begin
      phase_next     = phase_reg;
      idx_next       = idx_reg;
      wr_next        = wr_reg;
      rdy_next       = rdy_reg;
      rdata_next     = rdata_reg;
      t0_reload_next = t0_reload_reg;
      t1_ctrl_next   = t1_ctrl_reg;
      t1_reload_next = t1_reload_reg;
      unique case (phase_reg)
         PH_IDLE: begin
            if (hsel && htrans[1] && hready) begin
               phase_next = PH_WAIT;
               idx_next   = haddr[ADDR_W-1:2];
               wr_next    = hwrite;
               rdy_next   = 1'b0;
            end
         end
         PH_WAIT: begin
            // one wait state lets a read see the write just before it
            phase_next = PH_IDLE;
            rdy_next   = 1'b1;
            rdata_next = 32'h0000_0000;
            if (wr_reg) begin
               // reload writes touch only the stored value, not the count
               unique case (idx_reg)
                  IDX_T0_RELOAD_HI: t0_reload_next[15:8] = wdata;
                  IDX_T0_RELOAD_LO: t0_reload_next[7:0] = wdata;
                  IDX_T1_CONTROL:
                     t1_ctrl_next = wdata & CTRL_WRITE_MASK;
                  IDX_T1_RELOAD_HI: t1_reload_next[15:8] = wdata;
                  IDX_T1_RELOAD_LO: t1_reload_next[7:0] = wdata;
                  default: ;
               endcase
            end else begin
               unique case (idx_reg)
                  IDX_GROUP_CTRL:
                     rdata_next[7:0] = {2'h0, t1_run_reg, t0_run_reg,
                                        4'h0};
                  IDX_T0_RELOAD_HI: rdata_next[7:0] = t0_reload_reg[15:8];
                  IDX_T0_RELOAD_LO: rdata_next[7:0] = t0_reload_reg[7:0];
                  IDX_T0_COUNT_HI:  rdata_next[7:0] = t0_cnt_reg[15:8];
                  IDX_T0_COUNT_LO:  rdata_next[7:0] = t0_cnt_reg[7:0];
                  IDX_T1_CONTROL:   rdata_next[7:0] = t1_ctrl_reg;
                  IDX_T1_RELOAD_HI: rdata_next[7:0] = t1_reload_reg[15:8];
                  IDX_T1_RELOAD_LO: rdata_next[7:0] = t1_reload_reg[7:0];
                  IDX_T1_COUNT_HI:  rdata_next[7:0] = t1_cnt_reg[15:8];
                  IDX_T1_COUNT_LO:  rdata_next[7:0] = t1_cnt_reg[7:0];
                  IDX_IRQ_STATUS:   rdata_next[IRQ_FLAG_BIT] = irq_reg;
                  default: ;
               endcase
            end
         end
      endcase
   end

   // tick dividers and both timers
   always_comb begin
      logic [14:0] acc_sum;
      acc_sum        = {1'b0, acc_reg} + {1'b0, ACC_STEP};
      acc_next       = acc_sum[13:0];
      base_tick_next = 1'b0;
      // fractional divide: average rate is exact, spacing jitters by one
      if (acc_sum >= {1'b0, ACC_MOD}) begin
         acc_next       = 14'(acc_sum - {1'b0, ACC_MOD});
         base_tick_next = 1'b1;
      end
      slow_cnt_next  = slow_cnt_reg;
      slow_tick_next = 1'b0;
      if (base_tick_reg) begin
         slow_cnt_next  = slow_cnt_reg + 6'h01;
         slow_tick_next = (slow_cnt_reg == SLOW_LAST);
      end

      t0_cnt_next = t0_cnt_reg;
      t0_run_next = t0_run_reg;
      t0_uf_next  = 1'b0;
      if (t0_run_reg && base_tick_reg) begin
         if (t0_cnt_reg == 16'h0000) begin
            t0_uf_next  = 1'b1;
            t0_run_next = 1'b0;
         end else begin
            t0_cnt_next = t0_cnt_reg - 16'h0001;
         end
      end
      if (stop0) begin
         t0_run_next = 1'b0;
      end
      if (start0) begin
         t0_cnt_next = t0_reload_reg;
         t0_run_next = 1'b1;
      end

      t1_cnt_next = t1_cnt_reg;
      t1_run_next = t1_run_reg;
      t1_uf_next  = 1'b0;
      if (t1_run_reg && t1_tick) begin
         if (t1_cnt_reg == 16'h0000) begin
            // untimed trimming holds at zero with no underflow
            if (!trim_no_uf) begin
               t1_uf_next = 1'b1;
               if (t1_ctrl_reg[CTRL_AUTO_BIT]) begin
                  t1_cnt_next = t1_reload_reg;
               end else begin
                  t1_run_next = 1'b0;
               end
            end
         end else begin
            t1_cnt_next = t1_cnt_reg - 16'h0001;
         end
      end
      if (rx_nibble_done && t1_ctrl_reg[CTRL_STOP_RX_BIT] && !trim) begin
         t1_run_next = 1'b0;
      end
      if (trim && osc_rise) begin
         if (t1_run_reg) begin
            t1_run_next = 1'b0;
         end else begin
            t1_cnt_next = t1_reload_reg;
            t1_run_next = 1'b1;
         end
      end
      if (stop1) begin
         t1_run_next = 1'b0;
      end
      if (start1 || auto_start1) begin
         t1_cnt_next = t1_reload_reg;
         t1_run_next = 1'b1;
      end

      // new underflow wins over a clear in the same cycle
      irq_next = irq_reg;
      if (wr_en && (idx_reg == IDX_IRQ_STATUS) && wdata[IRQ_FLAG_BIT]) begin
         irq_next = 1'b0;
      end
      if (t1_uf_next) begin
         irq_next = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_reg     <= PH_IDLE;
         idx_reg       <= 8'h00;
         wr_reg        <= 1'b0;
         rdy_reg       <= 1'b1;
         rdata_reg     <= 32'h0000_0000;
         acc_reg       <= 14'h0000;
         base_tick_reg <= 1'b0;
         slow_cnt_reg  <= 6'h00;
         slow_tick_reg <= 1'b0;
         osc_s1_reg    <= 1'b0;
         osc_s2_reg    <= 1'b0;
         osc_s3_reg    <= 1'b0;
         t0_reload_reg <= RELOAD_RST;
         t0_cnt_reg    <= 16'h0000;
         t0_run_reg    <= 1'b0;
         t0_uf_reg     <= 1'b0;
         t1_ctrl_reg   <= CTRL_RST;
         t1_reload_reg <= RELOAD_RST;
         t1_cnt_reg    <= 16'h0000;
         t1_run_reg    <= 1'b0;
         t1_uf_reg     <= 1'b0;
         irq_reg       <= 1'b0;
      end else begin
         phase_reg     <= phase_next;
         idx_reg       <= idx_next;
         wr_reg        <= wr_next;
         rdy_reg       <= rdy_next;
         rdata_reg     <= rdata_next;
         acc_reg       <= acc_next;
         base_tick_reg <= base_tick_next;
         slow_cnt_reg  <= slow_cnt_next;
         slow_tick_reg <= slow_tick_next;
         osc_s1_reg    <= low_freq_oscillator;
         osc_s2_reg    <= osc_s1_reg;
         osc_s3_reg    <= osc_s2_reg;
         t0_reload_reg <= t0_reload_next;
         t0_cnt_reg    <= t0_cnt_next;
         t0_run_reg    <= t0_run_next;
         t0_uf_reg     <= t0_uf_next;
         t1_ctrl_reg   <= t1_ctrl_next;
         t1_reload_reg <= t1_reload_next;
         t1_cnt_reg    <= t1_cnt_next;
         t1_run_reg    <= t1_run_next;
         t1_uf_reg     <= t1_uf_next;
         irq_reg       <= irq_next;
      end
   end

   assign hrdata               = rdata_reg;
   assign hreadyout            = rdy_reg;
   assign hresp                = 1'b0;
   assign first_underflow      = t0_uf_reg;
   assign second_underflow     = t1_uf_reg;
   assign second_underflow_irq = irq_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_first_reload_load: assert property (
      start0 |=> t0_run_reg && t0_cnt_reg == $past(t0_reload_reg))
      else $error("first timer did not load reload on start");
   a_reload_no_disturb: assert property (
      (wr_en && idx_reg == IDX_T0_RELOAD_LO && !start0 && !base_tick_reg)
      |=> $stable(t0_cnt_reg))
      else $error("reload write disturbed running count");
   a_count_hi_read: assert property (
      (rd_en && idx_reg == IDX_T0_COUNT_HI)
      |=> hreadyout && hrdata == {24'h0, $past(t0_cnt_reg[15:8])})
      else $error("first count high byte readback wrong");
   a_stop_on_rx: assert property (
      (rx_nibble_done && t1_ctrl_reg[CTRL_STOP_RX_BIT] && !trim && !start1
       && !auto_start1) |=> !t1_run_reg)
      else $error("second timer kept running after receive nibble");
   a_trim_ignores_rx: assert property (
      (rx_nibble_done && trim && t1_run_reg && !osc_rise && !stop1
       && !t1_tick) |=> t1_run_reg)
      else $error("receive stopped timer in trimming mode");
   a_tx_auto_start: assert property (
      (tx_done && mode1 == START_TX_END)
      |=> t1_run_reg && t1_cnt_reg == $past(t1_reload_reg))
      else $error("no automatic start at end of transmit");
   a_auto_reload: assert property (
      (t1_run_reg && t1_tick && t1_cnt_reg == 16'h0000 && !trim
       && t1_ctrl_reg[CTRL_AUTO_BIT] && !stop1 && !rx_nibble_done)
      |=> t1_run_reg && t1_cnt_reg == $past(t1_reload_reg))
      else $error("auto reload did not restart count");
   a_halt_at_zero: assert property (
      (t1_run_reg && t1_tick && t1_cnt_reg == 16'h0000 && !trim
       && !t1_ctrl_reg[CTRL_AUTO_BIT] && !start1 && !auto_start1)
      |=> !t1_run_reg && second_underflow_irq)
      else $error("second timer did not halt at zero");
   a_underflow_irq: assert property (
      second_underflow |-> second_underflow_irq ##1 !second_underflow)
      else $error("underflow did not raise flag or pulse too long");
   a_reserved_zero: assert property (
      (rd_en && idx_reg == IDX_T1_CONTROL)
      |=> hrdata[6] == 1'b0 && hrdata[2] == 1'b0)
      else $error("reserved control bits read nonzero");

   a_ctrl_write_mask: assert property (
      (wr_en && idx_reg == IDX_T1_CONTROL)
      |=> t1_ctrl_reg == ($past(wdata) & CTRL_WRITE_MASK))
      else $error("second control write kept reserved bits");
   a_reload_hi_write: assert property (
      (wr_en && idx_reg == IDX_T1_RELOAD_HI)
      |=> t1_reload_reg[15:8] == $past(wdata))
      else $error("second reload high byte write lost");
   a_trim_no_uf: assert property (
      (t1_run_reg && t1_tick && t1_cnt_reg == 16'h0000 && trim_no_uf)
      |=> !second_underflow)
      else $error("untimed trimming mode produced an underflow");
   a_group_stop: assert property (
      (stop1 && !auto_start1) |=> !t1_run_reg)
      else $error("group stop did not halt second timer");
   a_first_uf_pulse: assert property (
      first_underflow |=> !first_underflow)
      else $error("first underflow pulse longer than one cycle");

endmodule
`default_nettype wire

// >>> dv/rtp_tb.sv
// testbench: register map and timer behaviour of the timer pair block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import rtp_pkg::*;
   logic        mclk;
   logic        rst;
   logic        hsel;
   logic [9:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        tx_done;
   logic        rx_nibble_done;
   logic        third_underflow;
   logic        low_freq_oscillator;
   logic        first_underflow;
   logic        second_underflow;
   logic        second_underflow_irq;
   int          num_errors;
   int          n_checks;
   int          cycles;
   int          n;
   logic [31:0] rd;
   logic [7:0]  mdl [int];
   logic [7:0]  rw_idx [5] = '{IDX_T0_RELOAD_HI, IDX_T0_RELOAD_LO,
      IDX_T1_CONTROL, IDX_T1_RELOAD_HI, IDX_T1_RELOAD_LO};
   logic [7:0]  ro_idx [5] = '{IDX_T0_COUNT_HI, IDX_T0_COUNT_LO,
      IDX_T1_COUNT_HI, IDX_T1_COUNT_LO, 8'h30};

   rtp_timer_regs #(.ADDR_W(10)) rtp_timer_regs_i (
      .mclk                 (mclk),
      .rst                  (rst),
      .hsel                 (hsel),
      .haddr                (haddr),
      .htrans               (htrans),
      .hwrite               (hwrite),
      .hsize                (hsize),
      .hwdata               (hwdata),
      .hready               (hreadyout),
      .hrdata               (hrdata),
      .hreadyout            (hreadyout),
      .hresp                (hresp),
      .tx_done              (tx_done),
      .rx_nibble_done       (rx_nibble_done),
      .third_underflow      (third_underflow),
      .low_freq_oscillator  (low_freq_oscillator),
      .first_underflow      (first_underflow),
      .second_underflow     (second_underflow),
      .second_underflow_irq (second_underflow_irq)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // the whole sequence needs a few thousand cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // one single ahb-lite transfer; waits on hready, never on a fixed count
   task automatic bus(input logic we, input logic [7:0] idx,
                      input logic [7:0] d);
      @(posedge mclk);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= we;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
      mdl[idx] = (idx == IDX_T1_CONTROL) ? (d & CTRL_WRITE_MASK) : d;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk(hresp, 1'b0);
   endtask

   task automatic wait_uf(input bit second, input int lim);
      n = 0;
      while ((second ? second_underflow : first_underflow) !== 1'b1
             && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask

   // 0 end of transmit, 1 first nibble, 2 third timer, 3 oscillator edge
   task automatic pulse(input int k);
      @(posedge mclk);
      case (k)
         0: tx_done <= 1'b1;
         1: rx_nibble_done <= 1'b1;
         2: third_underflow <= 1'b1;
         default: low_freq_oscillator <= 1'b1;
      endcase
      @(posedge mclk);
      {tx_done, rx_nibble_done, third_underflow} <= 3'h0;
      repeat (4) @(posedge mclk);
      low_freq_oscillator <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   initial begin
      {hsel, hwrite, tx_done, rx_nibble_done, third_underflow} = 5'h00;
      {haddr, htrans, hwdata, low_freq_oscillator} = '0;
      hsize = 3'h2;
      rst = 1'b1;
      num_errors = 0;
      n_checks = 0;
      cycles = 0;
      n = $urandom(32'h63C72BFE);
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      foreach (rw_idx[j]) rchk(rw_idx[j], 8'h00);
      rchk(IDX_GROUP_CTRL, 8'h00);
      for (int k = 0; k < 4; k++) begin
         foreach (rw_idx[j]) wr(rw_idx[j], 8'($urandom));
         foreach (ro_idx[j]) bus(1'b1, ro_idx[j], 8'($urandom));
         foreach (rw_idx[j]) rchk(rw_idx[j], mdl[rw_idx[j]]);
         foreach (ro_idx[j]) rchk(ro_idx[j], 8'h00);
      end
      wr(IDX_T1_CONTROL, 8'h00);
      // low byte 0xFF keeps the high byte still for many ticks
      wr(IDX_T0_RELOAD_HI, 8'h05);
      wr(IDX_T0_RELOAD_LO, 8'hFF);
      wr(IDX_GROUP_CTRL, 8'h10);
      rchk(IDX_GROUP_CTRL, 8'h00);
      wr(IDX_GROUP_CTRL, 8'h11);
      rchk(IDX_T0_COUNT_HI, 8'h05);
      wr(IDX_T0_RELOAD_HI, 8'h09);
      rchk(IDX_T0_COUNT_HI, 8'h05);
      wr(IDX_GROUP_CTRL, 8'h01);
      rchk(IDX_GROUP_CTRL, 8'h00);
      wr(IDX_GROUP_CTRL, 8'h11);
      rchk(IDX_T0_COUNT_HI, 8'h09);
      wr(IDX_T0_RELOAD_HI, 8'h00);
      wr(IDX_T0_RELOAD_LO, 8'h03);
      wr(IDX_GROUP_CTRL, 8'h11);
      wait_uf(0, 80);
      chk(n >= 19 && n <= 34, 1);
      @(posedge mclk);
      chk(first_underflow, 1'b0);
      rchk(IDX_T0_COUNT_LO, 8'h00);
      // second timer, base clock, auto reload from 2
      wr(IDX_T1_RELOAD_HI, 8'h00);
      wr(IDX_T1_RELOAD_LO, 8'h02);
      wr(IDX_T1_CONTROL, 8'h08);
      wr(IDX_GROUP_CTRL, 8'h22);
      wait_uf(1, 80);
      chk(n < 80, 1);
      @(posedge mclk);
      wait_uf(1, 80);
      chk(n >= 19 && n <= 25, 1);
      chk(second_underflow_irq, 1'b1);
      wr(IDX_GROUP_CTRL, 8'h02);
      rchk(IDX_IRQ_STATUS, 8'h01);
      wr(IDX_IRQ_STATUS, 8'h01);
      chk(second_underflow_irq, 1'b0);
      wr(IDX_T1_CONTROL, 8'h00);
      wr(IDX_GROUP_CTRL, 8'h22);
      wait_uf(1, 80);
      chk(n < 80, 1);
      rchk(IDX_GROUP_CTRL, 8'h00);
      rchk(IDX_T1_COUNT_LO, 8'h00);
      // slow clock: two slow ticks, far beyond two base ticks
      wr(IDX_T1_RELOAD_LO, 8'h01);
      wr(IDX_T1_CONTROL, 8'h01);
      wr(IDX_GROUP_CTRL, 8'h22);
      wait_uf(1, 1000);
      chk(n >= 450 && n < 960, 1);
      wr(IDX_IRQ_STATUS, 8'h01);
      wr(IDX_T1_CONTROL, 8'h03);
      wr(IDX_GROUP_CTRL, 8'h22);
      pulse(2);
      chk(second_underflow_irq, 1'b0);
      pulse(2);
      chk(second_underflow_irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h01);
      wr(IDX_T1_RELOAD_LO, 8'h00);
      wr(IDX_T1_CONTROL, 8'h02);
      wr(IDX_GROUP_CTRL, 8'h22);
      wr(IDX_GROUP_CTRL, 8'h11);
      chk(second_underflow_irq, 1'b0);
      wait_uf(0, 80);
      repeat (4) @(posedge mclk);
      chk(second_underflow_irq, 1'b1);
      wr(IDX_GROUP_CTRL, 8'h02);
      wr(IDX_T1_RELOAD_HI, 8'h0F);
      wr(IDX_T1_RELOAD_LO, 8'hFF);
      pulse(0);
      rchk(IDX_GROUP_CTRL, 8'h00);
      wr(IDX_T1_CONTROL, 8'h10);
      pulse(0);
      rchk(IDX_T1_COUNT_HI, 8'h0F);
      pulse(1);
      rchk(IDX_GROUP_CTRL, 8'h20);
      wr(IDX_GROUP_CTRL, 8'h02);
      wr(IDX_T1_CONTROL, 8'h90);
      pulse(0);
      pulse(1);
      rchk(IDX_GROUP_CTRL, 8'h00);
      for (int m = 2; m < 4; m++) begin
         wr(IDX_T1_CONTROL, 8'(8'h80 | (m << 4)));
         pulse(3);
         rchk(IDX_GROUP_CTRL, 8'h20);
         pulse(1);
         rchk(IDX_GROUP_CTRL, 8'h20);
         pulse(3);
         rchk(IDX_GROUP_CTRL, 8'h00);
         wr(IDX_T1_RELOAD_HI, 8'h00);
         wr(IDX_T1_RELOAD_LO, 8'h02);
         wr(IDX_IRQ_STATUS, 8'h01);
         pulse(3);
         repeat (60) @(posedge mclk);
         chk(second_underflow_irq, 1'(m == 3));
         wr(IDX_GROUP_CTRL, 8'h02);
         wr(IDX_T1_RELOAD_HI, 8'h0F);
         wr(IDX_T1_RELOAD_LO, 8'hFF);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
